//--- hw/dpe_map.vh
`ifndef DPE_MAP_VH
`define DPE_MAP_VH

// Register byte offsets (one 32-bit word each)
`define DPE_REG_CTRL 8'h00
`define DPE_REG_ANGLE 8'h04
`define DPE_REG_STG1_THR 8'h08
`define DPE_REG_STG1_DLY 8'h0c
`define DPE_REG_STG2_THR 8'h10
`define DPE_REG_STG2_DLY 8'h14
`define DPE_REG_CUTOFF 8'h18
`define DPE_REG_STATUS 8'h1c

// Field positions
`define DPE_CTRL_EN_BIT 0
`define DPE_ANGLE_RCA_LSB 0
`define DPE_ANGLE_CAL_LSB 16
`define DPE_ST_PKP1_BIT 0
`define DPE_ST_OP1_BIT 1
`define DPE_ST_PKP2_BIT 2
`define DPE_ST_OP2_BIT 3
`define DPE_ST_CUT_BIT 4
`define DPE_ST_BLK_BIT 5

// Reset values
`define DPE_RST_CTRL 1'h0
`define DPE_RST_RCA 9'h000
`define DPE_RST_CAL 5'h00
`define DPE_RST_THR 12'h064
`define DPE_RST_DLY1 16'h0032
`define DPE_RST_DLY2 16'h07d0
`define DPE_RST_CUTOFF 16'h0014

// Angle limits: coarse in whole degrees, fine in 0.05 degree steps
`define DPE_RCA_MAX 9'h167
`define DPE_CAL_MAX 5'h13
// Internal angle unit is 1/16 of a fine step (320 per degree)
`define DPE_DEG_UNITS 320
`define DPE_CAL_UNITS 16
`define DPE_QUARTER 18'h07080
`define DPE_CORDIC_ITERS 14
// CORDIC gain 1.64676 in Q14
`define DPE_GAIN 16'h6965
`define DPE_GAIN_SHIFT 14

// Delay step time in ms and clock rate in kHz
`define DPE_STEP_MS 10
`define DPE_CLK_KHZ 250000

`endif

//--- hw/dpe_stage.v
`timescale 1ns/1ps
`include "dpe_map.vh"

module dpe_stage
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Timing
  input wire stepTick,
  input wire [15:0] delaySteps,
  // Qualified pickup condition
  input wire pickupIn,
  // Indications
  output reg pickup_ff,
  output reg operate_ff
);

  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;

  // Delay counter runs while picked up and clears at once when pickup drops
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (!pickupIn)
      nxt_cnt = 16'h0000;
    else if (stepTick && (cnt_ff < delaySteps))
      nxt_cnt = cnt_ff + 16'h0001;
  end

  // Pickup and delayed operate flags
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_ff <= 16'h0000;
      pickup_ff <= 1'b0;
      operate_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      pickup_ff <= pickupIn;
      operate_ff <= pickupIn && (cnt_ff >= delaySteps);
    end
  end

endmodule // dpe_stage

//--- hw/dpe_top.v
`timescale 1ns/1ps
`include "dpe_map.vh"

// What this block does
// - The effective angle is the coarse characteristic angle plus the fine calibration angle.
// - A stage picks up when P*cos(angle) + Q*sin(angle) exceeds that stage's minimum operate power.
// - The fine calibration angle moves the effective angle in steps of 0.05 degrees.
// - Angles 0, 90, 180 and 270 degrees give active over, reactive over, active under and reactive under power.
// - Each stage takes a signed threshold; positive moves toward operate, negative toward restrain.
// - Thresholds are per unit of three-phase power, base three times VT base times CT base.
// - The element drops out whenever positive-sequence current is below the cutoff level.
// - Stage 1 operate follows its pickup after its own programmable delay.
// - Two stages have independent thresholds and delays and own pickup and operate outputs.
module dpe_top
#(
  parameter PW = 16,
  parameter TICK_CYCLES = `DPE_STEP_MS * `DPE_CLK_KHZ
)
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Metering inputs, power in 0.001 pu of the three-phase base
  input wire signed [PW-1:0] activePower,
  input wire signed [PW-1:0] reactivePower,
  input wire [15:0] posSeqCurrent,
  input wire blockIn,
  // Stage indications
  output wire stage1Pickup,
  output wire stage1Operate,
  output wire stage2Pickup,
  output wire stage2Operate
);

  localparam IW = PW + 3;
  localparam S_LOAD = 4'b0001;
  localparam S_QUAD = 4'b0010;
  localparam S_ROT = 4'b0100;
  localparam S_CMP = 4'b1000;

  // Byte-lane merge for register writes
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer b;
    begin
      be_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          be_merge[8*b +: 8] = data[8*b +: 8];
    end
  endfunction

  // Arctangent of 2^-i in internal angle units
  function [17:0] atan_units;
    input [3:0] i;
    begin
      case (i)
        4'h0: atan_units = 18'h03840;
        4'h1: atan_units = 18'h02135;
        4'h2: atan_units = 18'h0118c;
        4'h3: atan_units = 18'h008e8;
        4'h4: atan_units = 18'h00478;
        4'h5: atan_units = 18'h0023d;
        4'h6: atan_units = 18'h0011e;
        4'h7: atan_units = 18'h0008f;
        4'h8: atan_units = 18'h00048;
        4'h9: atan_units = 18'h00024;
        4'ha: atan_units = 18'h00012;
        4'hb: atan_units = 18'h00009;
        4'hc: atan_units = 18'h00004;
        default: atan_units = 18'h00002;
      endcase
    end
  endfunction

  reg ackFf_ff;
  reg enable_ff;
  reg [8:0] rca_ff;
  reg [4:0] cal_ff;
  reg [23:0] thr_ff;
  reg [31:0] dly_ff;
  reg [15:0] cutoff_ff;
  reg [31:0] nxt_rdata;
  reg [31:0] tickCnt_ff;
  reg stepTick_ff;
  reg [3:0] state_ff;
  reg [3:0] iter_ff;
  reg signed [IW-1:0] x_ff;
  reg signed [IW-1:0] y_ff;
  reg signed [17:0] z_ff;
  reg [1:0] raw_ff;
  reg [31:0] curWord;
  wire req;
  wire wrEn;
  wire [31:0] wval;
  wire [31:0] mergedWord;
  wire [31:0] angleSum;
  wire [17:0] effAngle;
  wire cutoffActive;
  wire [1:0] qualPickup;
  wire [1:0] pkp;
  wire [1:0] opr;
  wire signed [IW-1:0] xShift;
  wire signed [IW-1:0] yShift;

  // Slave answers one cycle after the request is seen
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ackFf_ff;
  assign wrEn = avs_write & ackFf_ff;
  assign wval = be_merge(32'h00000000, avs_writedata, avs_byteenable);
  assign mergedWord = be_merge(curWord, avs_writedata, avs_byteenable); // Unselected lanes keep the register

  // Settings registers; out-of-range angles saturate at the top of range
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      ackFf_ff <= 1'b0;
      enable_ff <= `DPE_RST_CTRL;
      rca_ff <= `DPE_RST_RCA;
      cal_ff <= `DPE_RST_CAL;
      thr_ff <= {`DPE_RST_THR, `DPE_RST_THR};
      dly_ff <= {`DPE_RST_DLY2, `DPE_RST_DLY1};
      cutoff_ff <= `DPE_RST_CUTOFF;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      ackFf_ff <= req & ~ackFf_ff;
      avs_readdata <= nxt_rdata;
      if (wrEn)
      begin
        case (avs_address)
          `DPE_REG_CTRL:
            if (avs_byteenable[0])
              enable_ff <= avs_writedata[`DPE_CTRL_EN_BIT];
          `DPE_REG_ANGLE:
          begin
            if (avs_byteenable[1:0] == 2'b11)
              rca_ff <= (wval[8:0] > `DPE_RCA_MAX) ? `DPE_RCA_MAX : wval[8:0];
            if (avs_byteenable[2])
              cal_ff <= (wval[20:16] > `DPE_CAL_MAX) ? `DPE_CAL_MAX : wval[20:16];
          end
          `DPE_REG_STG1_THR:
            thr_ff[11:0] <= mergedWord[11:0];
          `DPE_REG_STG1_DLY:
            dly_ff[15:0] <= mergedWord[15:0];
          `DPE_REG_STG2_THR:
            thr_ff[23:12] <= mergedWord[11:0];
          `DPE_REG_STG2_DLY:
            dly_ff[31:16] <= mergedWord[15:0];
          `DPE_REG_CUTOFF:
            cutoff_ff <= mergedWord[15:0];
          default:
            enable_ff <= enable_ff;
        endcase
      end
    end
  end

  // Register word at the bus address; read data only while the read still waits
  always @*
  begin
    curWord = 32'h00000000;
    case (avs_address)
      `DPE_REG_CTRL: curWord[`DPE_CTRL_EN_BIT] = enable_ff;
      `DPE_REG_ANGLE: curWord = {11'h000, cal_ff, 7'h00, rca_ff};
      `DPE_REG_STG1_THR: curWord = {{20{thr_ff[11]}}, thr_ff[11:0]};
      `DPE_REG_STG1_DLY: curWord = {16'h0000, dly_ff[15:0]};
      `DPE_REG_STG2_THR: curWord = {{20{thr_ff[23]}}, thr_ff[23:12]};
      `DPE_REG_STG2_DLY: curWord = {16'h0000, dly_ff[31:16]};
      `DPE_REG_CUTOFF: curWord = {16'h0000, cutoff_ff};
      `DPE_REG_STATUS:
        curWord = {26'h0000000, blockIn, cutoffActive, opr[1], pkp[1], opr[0], pkp[0]};
      default: curWord = 32'h00000000;
    endcase
    nxt_rdata = (avs_read && !ackFf_ff) ? curWord : 32'h00000000;
  end

  // Delay step divider, one pulse per 10 ms
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      tickCnt_ff <= 32'h00000000;
      stepTick_ff <= 1'b0;
    end
    else
    begin
      stepTick_ff <= (tickCnt_ff == TICK_CYCLES - 1);
      tickCnt_ff <= (tickCnt_ff == TICK_CYCLES - 1) ? 32'h00000000 : tickCnt_ff + 32'h00000001;
    end
  end

  // Effective angle = coarse degrees plus fine 0.05 degree steps
  assign angleSum = rca_ff * `DPE_DEG_UNITS + cal_ff * `DPE_CAL_UNITS;
  assign effAngle = angleSum[17:0]; // Largest sum stays below 2^17
  assign xShift = x_ff >>> iter_ff;
  assign yShift = y_ff >>> iter_ff;

  // Rotate (P,Q) by minus the angle; x ends as gain*(P cos + Q sin)
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff <= S_LOAD;
      iter_ff <= 4'h0;
      x_ff <= {IW{1'b0}};
      y_ff <= {IW{1'b0}};
      z_ff <= 18'sh00000;
      raw_ff <= 2'b00;
    end
    else
    begin
      case (state_ff)
        S_LOAD:
        begin
          x_ff <= {{3{activePower[PW-1]}}, activePower};
          y_ff <= {{3{reactivePower[PW-1]}}, reactivePower};
          z_ff <= effAngle;
          iter_ff <= 4'h0;
          state_ff <= S_QUAD;
        end
        S_QUAD:
          // Whole quarter turns first: 90, 180, 270 degrees map P and Q exactly
          if (z_ff >= $signed(`DPE_QUARTER))
          begin
            x_ff <= y_ff;
            y_ff <= -x_ff;
            z_ff <= z_ff - $signed(`DPE_QUARTER);
          end
          else
            state_ff <= S_ROT;
        S_ROT:
        begin
          if (!z_ff[17])
          begin
            x_ff <= x_ff + yShift;
            y_ff <= y_ff - xShift;
            z_ff <= z_ff - $signed(atan_units(iter_ff));
          end
          else
          begin
            x_ff <= x_ff - yShift;
            y_ff <= y_ff + xShift;
            z_ff <= z_ff + $signed(atan_units(iter_ff));
          end
          iter_ff <= iter_ff + 4'h1;
          if (iter_ff == `DPE_CORDIC_ITERS - 1)
            state_ff <= S_CMP;
        end
        S_CMP:
        begin
          raw_ff <= {x_ff > thrScaled(thr_ff[23:12]), x_ff > thrScaled(thr_ff[11:0])};
          state_ff <= S_LOAD;
        end
        default:
          state_ff <= S_LOAD;
      endcase
    end
  end

  // Threshold scaled by the rotation gain so it compares with x directly
  function signed [IW-1:0] thrScaled;
    input [11:0] thr;
    reg signed [27:0] prod;
    begin
      prod = $signed(thr) * $signed(`DPE_GAIN);
      thrScaled = {{(IW-14){prod[27]}}, prod[27:14]};
    end
  endfunction

  // Drop out below current cutoff, when disabled, or when blocked
  assign cutoffActive = posSeqCurrent < cutoff_ff;
  assign qualPickup = raw_ff & {2{enable_ff & ~blockIn & ~cutoffActive}};

  // Two independent stages
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gStage
      dpe_stage uStage
      (
        .core_clk(core_clk),
        .srst(srst),
        .stepTick(stepTick_ff),
        .delaySteps(dly_ff[16*g +: 16]),
        .pickupIn(qualPickup[g]),
        .pickup_ff(pkp[g]),
        .operate_ff(opr[g])
      );
    end
  endgenerate

  assign stage1Pickup = pkp[0];
  assign stage1Operate = opr[0];
  assign stage2Pickup = pkp[1];
  assign stage2Operate = opr[1];

endmodule // dpe_top

//--- testbench/dpe_asserts.sv
`timescale 1ns/1ps
module dpe_asserts
#(
  parameter TICK_CYCLES = 10
)
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Register bus
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Metering and stages
  input wire [15:0] posSeqCurrent,
  input wire blockIn,
  input wire stage1Pickup,
  input wire stage1Operate,
  input wire stage2Pickup,
  input wire stage2Operate
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Bus answers one cycle after a request rises
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle");
  property p_alt;
    (avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest || !(avs_read || avs_write);
  endproperty
  a_alt: assert property (p_alt) else $error("bus acked twice in a row");
  property p_rdz;
    $fell(avs_read) |-> avs_readdata == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data not cleared");
  // Stage outputs against block, cutoff and pickup
  property p_blk;
    blockIn [*2] |-> !(stage1Pickup || stage1Operate || stage2Pickup || stage2Operate);
  endproperty
  a_blk: assert property (p_blk) else $error("output while blocked");
  property p_cut;
    (posSeqCurrent == 16'h0000) [*3] |-> !stage1Pickup && !stage2Pickup;
  endproperty
  a_cut: assert property (p_cut) else $error("pickup with no current");
  property p_op1;
    stage1Operate |-> stage1Pickup;
  endproperty
  a_op1: assert property (p_op1) else $error("stage one operate alone");
  property p_op2;
    stage2Operate |-> stage2Pickup;
  endproperty
  a_op2: assert property (p_op2) else $error("stage two operate alone");
  property p_rise1;
    $rose(stage1Operate) |-> $past(stage1Pickup, 8);
  endproperty
  a_rise1: assert property (p_rise1) else $error("stage one operate early");
  property p_rise2;
    $rose(stage2Operate) |-> $past(stage2Pickup, 8);
  endproperty
  a_rise2: assert property (p_rise2) else $error("stage two operate early");
endmodule // dpe_asserts

bind dpe_top dpe_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk
(
  .core_clk(core_clk),
  .srst(srst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .posSeqCurrent(posSeqCurrent),
  .blockIn(blockIn),
  .stage1Pickup(stage1Pickup),
  .stage1Operate(stage1Operate),
  .stage2Pickup(stage2Pickup),
  .stage2Operate(stage2Operate)
);

//--- testbench/dpe_meter.sv
`timescale 1ns/1ps
module dpe_meter
#(
  parameter RATE = 3
)
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Requested quantities
  input wire signed [15:0] pSet,
  input wire signed [15:0] qSet,
  input wire [15:0] iSet,
  // Measured quantities
  output reg signed [15:0] pOut_ff = 16'sh0000,
  output reg signed [15:0] qOut_ff = 16'sh0000,
  output reg [15:0] iOut_ff = 16'h0000
);
  reg [3:0] cnt_ff = 4'h0;
  // Values move only at each metering update, so the block sees stale data
  always @(posedge core_clk)
  begin
    cnt_ff <= (srst || cnt_ff == RATE) ? 4'h0 : cnt_ff + 4'h1;
    if (srst || cnt_ff == RATE)
    begin
      pOut_ff <= pSet;
      qOut_ff <= qSet;
      iOut_ff <= iSet;
    end
  end
endmodule // dpe_meter

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`include "dpe_map.vh"
module tb_top;
  // Bench signals
  logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, blockIn = 0;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, s1p, s1o, s2p, s2o;
  logic signed [15:0] pSet = 0, qSet = 0;
  logic [15:0] iSet = 0;
  wire signed [15:0] actPow, reaPow;
  wire [15:0] curMag;
  int miscompares = 0, compares = 0, cyc = 0, n, m;

  dpe_top #(.PW(16), .TICK_CYCLES(10)) u_dut
  (
    .core_clk(core_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .activePower(actPow),
    .reactivePower(reaPow),
    .posSeqCurrent(curMag),
    .blockIn(blockIn),
    .stage1Pickup(s1p),
    .stage1Operate(s1o),
    .stage2Pickup(s2p),
    .stage2Operate(s2o)
  );
  dpe_meter #(.RATE(3)) u_meter
  (
    .core_clk(core_clk),
    .srst(srst),
    .pSet(pSet),
    .qSet(qSet),
    .iSet(iSet),
    .pOut_ff(actPow),
    .qOut_ff(reaPow),
    .iOut_ff(curMag)
  );

  initial forever #2 core_clk = ~core_clk;

  task summarize;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      miscompares++;
      summarize();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One bus access, held until waitrequest is sampled low at a rising edge
  task xfer(input logic r, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    begin
      @(posedge core_clk);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge core_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  // New metering values, then time for an evaluation
  task put(input logic signed [15:0] p, input logic signed [15:0] qq, input logic [15:0] i);
    begin
      @(posedge core_clk);
      pSet <= p;
      qSet <= qq;
      iSet <= i;
      repeat (50) @(posedge core_clk); // Meter lag, one missed and one full evaluation
      @(negedge core_clk);
    end
  endtask

  task pk(input logic signed [15:0] p, input logic signed [15:0] qq, input logic [15:0] i, input logic e);
    begin
      put(p, qq, i);
      chk("pkp1", 32'(s1p), 32'(e));
    end
  endtask

  task s_regs;
    logic [31:0] rv [9] = '{0, 0, 32'h64, 32'h32, 32'h64, 32'h7d0, 32'h14, 32'h10, 0};
    begin
      for (int k = 0; k < 9; k++)
      begin
        xfer(1, 8'(k * 4), 0, q);
        chk("reg", q, rv[k]);
      end
      xfer(0, `DPE_REG_ANGLE, 32'h001f_ffff, q);
      xfer(1, `DPE_REG_ANGLE, 0, q);
      chk("sat", q, 32'h0013_0167);
    end
  endtask

  task s_dir;
    logic signed [15:0] pv [4] = '{16'sd500, 0, -16'sd500, 0};
    logic signed [15:0] qv [4] = '{0, 16'sd500, 0, -16'sd500};
    begin
      xfer(0, `DPE_REG_CTRL, 32'h1, q);
      for (int k = 0; k < 4; k++)
      begin
        xfer(0, `DPE_REG_ANGLE, 32'(k * 90), q);
        pk(pv[k], qv[k], 16'd1000, 1);
        pk(-pv[k], -qv[k], 16'd1000, 0);
      end
      xfer(0, `DPE_REG_ANGLE, 32'h0013_005a, q);
      pk(-16'sd10000, 0, 16'd1000, 1);
      xfer(0, `DPE_REG_ANGLE, 32'h5a, q);
      pk(-16'sd10000, 0, 16'd1000, 0);
      xfer(0, `DPE_REG_ANGLE, 0, q);
      xfer(0, `DPE_REG_STG1_THR, 32'hf9c, q);
      pk(-16'sd50, 0, 16'd1000, 1);
      pk(-16'sd150, 0, 16'd1000, 0);
      xfer(0, `DPE_REG_STG1_THR, 32'h64, q);
      pk(500, 0, 16'd19, 0);
      pk(500, 0, 16'd20, 1);
    end
  endtask

  task s_stage;
    begin
      xfer(0, `DPE_REG_STG2_THR, 32'h3e8, q);
      xfer(0, `DPE_REG_STG1_DLY, 32'h3, q);
      xfer(0, `DPE_REG_STG2_DLY, 32'h2, q);
      put(500, 0, 16'd1000);
      chk("pkp2", 32'(s2p), 0);
      put(0, 0, 16'd1000);
      @(posedge core_clk);
      pSet <= 16'sd1500;
      n = 0;
      while (s1p !== 1'b1 && n < 100)
      begin
        @(negedge core_clk);
        n++;
      end
      m = 0;
      while (s1o !== 1'b1 && m < 100)
      begin
        @(negedge core_clk);
        m++;
      end
      chk("dly1", 32'(m >= 19 && m <= 31), 1);
      put(1500, 0, 16'd1000);
      chk("op2", 32'(s2o), 1);
      @(posedge core_clk);
      blockIn <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk("blk", 32'({s1p, s1o, s2p, s2o}), 0);
      @(posedge core_clk);
      blockIn <= 1'b0;
      xfer(0, `DPE_REG_CTRL, 0, q);
      put(1500, 0, 16'd1000);
      chk("dis", 32'({s1p, s2p}), 0);
    end
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    s_regs();
    s_dir();
    s_stage();
    summarize();
  end
endmodule // tb_top
